// File: verilog/scg_params.svh
// Purpose: constants for the secondary clock gating and strap block
// Assumes: 32-bit Avalon-MM register words, byte addressing
// Notes:   offsets are byte addresses, one aligned word per register
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// register byte offsets
`define SCG_CLK_CTRL_OFS     5'h00
`define SCG_MASK_OFS         5'h04
`define SCG_BRIDGE_CTRL_OFS  5'h08
`define SCG_PM_CTRL_OFS      5'h0C
`define SCG_STATUS_OFS       5'h10

// reset values
`define SCG_CLK_CTRL_RST     10'h000
`define SCG_MASK_RST         10'h000
`define SCG_BRIDGE_CTRL_RST  1'h0
`define SCG_PM_CTRL_RST      2'h0

// field positions
`define SCG_BRIDGE_SEC_RESET_BIT 0
`define SCG_STAT_SPEED_BIT       0
`define SCG_STAT_SCAN_SHIFT_BIT  1
`define SCG_STAT_RESERVED_BIT    2
`define SCG_STAT_COMPAT_BIT      3
`define SCG_STAT_LOADED_BIT      4
`define SCG_STAT_FEEDBACK_BIT    5
`define SCG_STAT_BPC_STRAP_BIT   6
`define SCG_STAT_B2_BIT          7
`define SCG_STAT_WINDOW_BIT      8

// timing counts
`define SCG_CLK_HALF_DEFAULT     1
`define SCG_SEC_HOLD_DEFAULT     64

`endif

// File: verilog/scg_pkg.sv
// Purpose: shared types of the secondary clock gating block
// Assumes: nothing beyond the params header
// Notes:   power state codes follow the usual PCI PM encoding
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_PM_D0     = 2'h0,
        SCG_PM_D1     = 2'h1,
        SCG_PM_D2     = 2'h2,
        SCG_PM_D3HOT  = 2'h3
    } scg_pm_state_type;

    typedef enum logic [1:0] {
        SCG_LD_IDLE,
        SCG_LD_SHIFT,
        SCG_LD_DONE
    } scg_load_state_type;
endpackage

// File: verilog/scg_mask_if.sv
// Purpose: carries the serial mask between controller and loader
// Assumes: one clock domain, mclk
// Notes:   mask width is a parameter
`timescale 1ns/1ps
`default_nettype none
interface scg_mask_if #(parameter int NUM_CLK = 10);
    logic               strobe;
    logic               serial_bit;
    logic               window;
    logic               done;
    logic [NUM_CLK-1:0] mask;

    modport loader (input strobe, input serial_bit, input window,
                    output done, output mask);
    modport ctrl   (output strobe, output serial_bit, output window,
                    input done, input mask);
endinterface
`default_nettype wire

// File: verilog/scg_mask_loader.sv
// Purpose: shifts the serial clock disable mask in during reset window
// Assumes: strobe and serial bit are synchronous to mclk
// Notes:   first bit received ends up in the highest mask bit
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_mask_loader #(
    parameter int NUM_CLK = 10
) (
    input  wire logic   mclk,
    input  wire logic   reset,
    scg_mask_if.loader  mbus
);
    import scg_pkg::*;

    // the shift needs two bits at least and the counter holds six
    if (NUM_CLK < 2 || NUM_CLK > 32) begin : g_bad_num
        $error("NUM_CLK must lie in 2..32");
    end

    scg_load_state_type state_reg;
    scg_load_state_type state_next;
    logic [NUM_CLK-1:0] mask_reg;
    logic [NUM_CLK-1:0] mask_next;
    logic [5:0]         count_reg;
    logic [5:0]         count_next;

    localparam logic [5:0] LAST = 6'(NUM_CLK - 1);

    wire take_bit = (state_reg == SCG_LD_SHIFT) && mbus.strobe;

    // window opening clears the mask so a low pin leaves all enabled
    always_comb begin
        state_next = state_reg;
        mask_next  = mask_reg;
        count_next = count_reg;
        case (state_reg)
            SCG_LD_IDLE: begin
                if (mbus.window) begin
                    state_next = SCG_LD_SHIFT;
                    mask_next  = '0;
                    count_next = '0;
                end
            end
            SCG_LD_SHIFT: begin
                if (!mbus.window) begin
                    state_next = SCG_LD_IDLE;
                end else if (take_bit) begin
                    mask_next  = {mask_reg[NUM_CLK-2:0], mbus.serial_bit};
                    count_next = count_reg + 6'h01;
                    if (count_reg == LAST) begin
                        state_next = SCG_LD_DONE;
                    end
                end
            end
            SCG_LD_DONE: begin
                if (!mbus.window) begin
                    state_next = SCG_LD_IDLE;
                end
            end
            default: state_next = SCG_LD_IDLE;
        endcase
    end

    // state and mask storage
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= SCG_LD_IDLE;
            mask_reg  <= NUM_CLK'(`SCG_MASK_RST);
            count_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            mask_reg  <= mask_next;
            count_reg <= count_next;
        end
    end

    assign mbus.mask = mask_reg;
    assign mbus.done = (state_reg == SCG_LD_DONE);

    chk_shift_outside_window: assert property (
        @(posedge mclk) disable iff (reset)
        (!mbus.window && state_reg != SCG_LD_SHIFT) |=> $stable(mask_reg))
        else $error("mask changed outside the load window");

    chk_mask_bit_taken: assert property (
        @(posedge mclk) disable iff (reset)
        take_bit && mbus.window |=> mask_reg[0] == $past(mbus.serial_bit))
        else $error("mask bit not shifted in");

    chk_one_bit_strobe: assert property (
        @(posedge mclk) disable iff (reset)
        take_bit && mbus.window |=> count_reg == $past(count_reg) + 6'h01)
        else $error("strobe did not count exactly one bit");
endmodule
`default_nettype wire

// File: verilog/scg_clock_ctrl.sv
// Purpose: secondary clock outputs, mask window, straps, register file
// Assumes: mclk is the primary clock; pins synchronous to mclk
// Notes:   disabled clocks park high, B2 parks them low
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_clock_ctrl #(
    parameter int NUM_CLK       = 10,
    parameter int CLK_HALF      = `SCG_CLK_HALF_DEFAULT,
    parameter int SEC_HOLD      = `SCG_SEC_HOLD_DEFAULT
) (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               primary_reset_n,
    input  wire logic               clock_mask_serial_in,
    input  wire logic               clock_mask_strobe,
    input  wire logic               bus_power_clock_strap,
    input  wire logic               speed_strap,
    input  wire logic               test_mode,
    input  wire logic               mode_select_a,
    input  wire logic               mode_select_b,
    input  wire logic               secondary_clock_feedback,
    output logic [NUM_CLK-1:0]      secondary_clock_out,
    output logic                    secondary_reset_n,
    output logic                    speed_66mhz,
    output logic                    scan_shift_en,
    output logic                    mode_compat,
    output logic                    mode_reserved
);
    import scg_pkg::*;

    // refuse sizes the counters and register words cannot hold
    if (NUM_CLK < 2 || NUM_CLK > 32) begin : g_bad_num
        $error("NUM_CLK must lie in 2..32");
    end
    if (CLK_HALF < 1 || CLK_HALF > 255) begin : g_bad_half
        $error("CLK_HALF must lie in 1..255");
    end
    if (SEC_HOLD < 1 || SEC_HOLD > 65535) begin : g_bad_hold
        $error("SEC_HOLD must lie in 1..65535");
    end

    localparam logic [7:0]  HALF_LAST = 8'(CLK_HALF - 1);
    localparam logic [15:0] HOLD_INIT = 16'(SEC_HOLD);

    logic [NUM_CLK-1:0] clk_ctrl_reg;
    logic               bridge_sec_reset_reg;
    scg_pm_state_type   pm_reg;
    logic               wait_reg;
    logic [31:0]        rdata_reg;
    logic [7:0]         div_reg;
    logic               phase_reg;
    logic [15:0]        hold_reg;
    logic               sec_reset_reg;
    logic               sec_reset_n_reg;
    logic [NUM_CLK-1:0] clk_out_reg;
    logic               feedback_reg;
    logic               speed_reg;
    logic               scan_reg;
    logic               compat_reg;
    logic               reserved_reg;

    scg_mask_if #(.NUM_CLK(NUM_CLK)) mbus ();

    // the loader only listens while primary is out of reset
    // and secondary is still held
    assign mbus.window     = primary_reset_n && sec_reset_reg;
    assign mbus.strobe     = clock_mask_strobe;
    assign mbus.serial_bit = clock_mask_serial_in;

    scg_mask_loader #(.NUM_CLK(NUM_CLK)) u_loader (
        .mclk  (mclk),
        .reset (reset),
        .mbus  (mbus)
    );

    // bus decode; a request is served on the second cycle it is held
    wire        bus_req    = avs_read || avs_write;
    wire        bus_commit = avs_write && !wait_reg;
    wire        hit_ctrl   = (avs_address == `SCG_CLK_CTRL_OFS);
    wire        hit_mask   = (avs_address == `SCG_MASK_OFS);
    wire        hit_bridge = (avs_address == `SCG_BRIDGE_CTRL_OFS);
    wire        hit_pm     = (avs_address == `SCG_PM_CTRL_OFS);
    wire        hit_status = (avs_address == `SCG_STATUS_OFS);
    wire [31:0] lane_mask  = {{8{avs_byteenable[3]}},
                              {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}},
                              {8{avs_byteenable[0]}}};
    wire [31:0] wr_bits    = avs_writedata & lane_mask;
    wire [31:0] keep_bits  = ~lane_mask;

    // merged write values, only enabled lanes change
    wire [31:0] ctrl_wide  = 32'(clk_ctrl_reg);
    wire [31:0] ctrl_merge = (ctrl_wide & keep_bits) | wr_bits;
    wire [NUM_CLK-1:0] clk_ctrl_next = hit_ctrl && bus_commit ?
                                       ctrl_merge[NUM_CLK-1:0] :
                                       clk_ctrl_reg;
    wire bridge_next = hit_bridge && bus_commit && avs_byteenable[0] ?
                       avs_writedata[`SCG_BRIDGE_SEC_RESET_BIT] :
                       bridge_sec_reset_reg;
    wire pm_wr = hit_pm && bus_commit && avs_byteenable[0];

    // status word, read-only view of the block's own state
    wire        b2_gate;
    wire [31:0] status_word;
    assign status_word = {23'h000000,
                          mbus.window,
                          b2_gate,
                          bus_power_clock_strap,
                          feedback_reg,
                          mbus.done,
                          compat_reg,
                          reserved_reg,
                          scan_reg,
                          speed_reg};

    // read selection; unmapped addresses read as zero
    wire [31:0] rdata_next = hit_ctrl   ? 32'(clk_ctrl_reg) :
                             hit_mask   ? 32'(mbus.mask) :
                             hit_bridge ? 32'(bridge_sec_reset_reg) :
                             hit_pm     ? 32'(pm_reg) :
                             hit_status ? status_word :
                                          32'h00000000;

    // bus handshake and registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_reg             <= 1'b1;
            rdata_reg            <= 32'h00000000;
            clk_ctrl_reg         <= NUM_CLK'(`SCG_CLK_CTRL_RST);
            bridge_sec_reset_reg <= `SCG_BRIDGE_CTRL_RST;
            pm_reg               <= scg_pm_state_type'(`SCG_PM_CTRL_RST);
        end else begin
            wait_reg             <= !(bus_req && wait_reg);
            rdata_reg            <= bus_req && wait_reg ? rdata_next :
                                    rdata_reg;
            clk_ctrl_reg         <= clk_ctrl_next;
            bridge_sec_reset_reg <= bridge_next;
            if (pm_wr) begin
                pm_reg <= scg_pm_state_type'(avs_writedata[1:0]);
            end
        end
    end

    // secondary reset: primary reset, control bit, or the hold
    // window after primary release that gives the mask time to load
    wire hold_busy      = (hold_reg != 16'h0000);
    wire sec_reset_next = !primary_reset_n || bridge_sec_reset_reg ||
                          hold_busy;
    always_ff @(posedge mclk) begin
        if (reset) begin
            hold_reg        <= HOLD_INIT;
            sec_reset_reg   <= 1'b1;
            sec_reset_n_reg <= 1'b0;
        end else begin
            hold_reg        <= !primary_reset_n ? HOLD_INIT :
                               hold_busy ? hold_reg - 16'h0001 : hold_reg;
            sec_reset_reg   <= sec_reset_next;
            sec_reset_n_reg <= !sec_reset_next; // pin stays glitch free
        end
    end

    // divider gives one toggle enable per half period of the
    // secondary clock, so all outputs share phase with mclk
    wire tick       = (div_reg == HALF_LAST);
    wire phase_next = tick ? !phase_reg : phase_reg;
    always_ff @(posedge mclk) begin
        if (reset) begin
            div_reg   <= 8'h00;
            phase_reg <= 1'b0;
        end else begin
            div_reg   <= tick ? 8'h00 : div_reg + 8'h01;
            phase_reg <= phase_next;
        end
    end

    // B2 only when the strap allows it; strap low ignores D3hot
    assign b2_gate = bus_power_clock_strap &&
                     (pm_reg == SCG_PM_D3HOT);
    wire [NUM_CLK-1:0] clk_disable = mbus.mask | clk_ctrl_reg;

    // per output gate: B2 forces low, a disable bit parks high
    for (genvar i = 0; i < NUM_CLK; i++) begin : g_clk
        wire gated_level = b2_gate        ? 1'b0 :
                           clk_disable[i] ? 1'b1 :
                                            phase_next;
        always_ff @(posedge mclk) begin
            if (reset) begin
                clk_out_reg[i] <= 1'b0;
            end else begin
                clk_out_reg[i] <= gated_level;
            end
        end
    end

    // strap decode; in test the speed pin, when low, doubles as scan enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            feedback_reg <= 1'b0;
            speed_reg    <= 1'b0;
            scan_reg     <= 1'b0;
            compat_reg   <= 1'b0;
            reserved_reg <= 1'b0;
        end else begin
            feedback_reg <= secondary_clock_feedback;
            speed_reg    <= !test_mode && speed_strap;
            scan_reg     <= test_mode && !speed_strap;
            compat_reg   <= mode_select_a;
            reserved_reg <= !mode_select_a && !mode_select_b;
        end
    end

    assign avs_readdata        = rdata_reg;
    assign avs_waitrequest     = wait_reg;
    assign secondary_clock_out = clk_out_reg;
    assign secondary_reset_n   = sec_reset_n_reg;
    assign speed_66mhz         = speed_reg;
    assign scan_shift_en       = scan_reg;
    assign mode_compat         = compat_reg;
    assign mode_reserved       = reserved_reg;

    chk_low_mask_runs: assert property (
        @(posedge mclk) disable iff (reset)
        (!b2_gate && clk_disable == '0) |=>
            secondary_clock_out == {NUM_CLK{phase_reg}})
        else $error("enabled clocks do not follow the phase");

    chk_high_mask_park: assert property (
        @(posedge mclk) disable iff (reset)
        (!b2_gate && &mbus.mask) |=> &secondary_clock_out)
        else $error("masked clocks not parked high");

    chk_b2_drives_low: assert property (
        @(posedge mclk) disable iff (reset)
        (bus_power_clock_strap && pm_reg == SCG_PM_D3HOT) |=>
            secondary_clock_out == '0)
        else $error("B2 did not drive clocks low");

    chk_strap_low_free: assert property (
        @(posedge mclk) disable iff (reset)
        (!bus_power_clock_strap && !clk_disable[0]) |=>
            secondary_clock_out[0] == phase_reg)
        else $error("D3hot stopped clocks with strap low");

    chk_speed_decode: assert property (
        @(posedge mclk) disable iff (reset)
        !test_mode ##1 !$past(test_mode) |->
            speed_66mhz == $past(speed_strap))
        else $error("speed strap decoded wrongly");

    chk_scan_decode: assert property (
        @(posedge mclk) disable iff (reset)
        test_mode |=> scan_shift_en == !$past(speed_strap) && !speed_66mhz)
        else $error("scan enable decoded wrongly");

    chk_mode_decode: assert property (
        @(posedge mclk) disable iff (reset)
        mode_select_a |=> mode_compat && !mode_reserved)
        else $error("mode select decoded wrongly");

    chk_clock_toggles: assert property (
        @(posedge mclk) disable iff (reset)
        (!b2_gate && !clk_disable[0]) ##1
        (!b2_gate && !clk_disable[0] && tick) |=>
            secondary_clock_out[0] != $past(secondary_clock_out[0]))
        else $error("enabled clock failed to toggle");

    chk_sw_disable: assert property (
        @(posedge mclk) disable iff (reset)
        (!b2_gate && clk_ctrl_reg[0]) |=> secondary_clock_out[0])
        else $error("software disable not honoured");

    chk_sec_reset: assert property (
        @(posedge mclk) disable iff (reset)
        (!primary_reset_n || bridge_sec_reset_reg) |=> !secondary_reset_n)
        else $error("secondary reset not asserted");

    chk_bus_answer: assert property (
        @(posedge mclk) disable iff (reset)
        (bus_req && wait_reg) |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
endmodule
`default_nettype wire

// File: tb/scg_board_model.sv
// Purpose: board side of the block: primary reset pin and serial mask source
// Assumes: one strobe per mask bit, all timed on mclk rising edges
// Notes:   first bit sent is mask bit 9; idle serial line toggles unless hold_level is set
`timescale 1ns/1ps
`default_nettype none
module scg_board_model (
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic       with_reset,
    input  wire logic       hold_level,
    input  wire logic       slow,
    input  wire logic [9:0] mask_value,
    output logic            primary_reset_n,
    output logic            clock_mask_serial_in,
    output logic            clock_mask_strobe,
    output logic            busy
);
    initial begin
        primary_reset_n      = 1'b1;
        clock_mask_serial_in = 1'b0;
        clock_mask_strobe    = 1'b0;
        busy                 = 1'b0;
    end

    // one sequence per go pulse; without reset the strobes land outside
    // the window on purpose, which the block must ignore
    always begin
        @(posedge mclk);
        if (go === 1'b1) begin
            busy <= 1'b1;
            if (with_reset) begin
                primary_reset_n <= 1'b0;
                repeat (3) @(posedge mclk);
                primary_reset_n <= 1'b1;
                repeat (2) @(posedge mclk);
            end
            for (int i = 9; i >= 0; i--) begin
                clock_mask_serial_in <= mask_value[i];
                clock_mask_strobe    <= 1'b1;
                @(posedge mclk);
                if (slow) begin
                    clock_mask_strobe <= 1'b0;
                    if (!hold_level)
                        clock_mask_serial_in <= ~mask_value[i];
                    @(posedge mclk);
                end
            end
            clock_mask_strobe <= 1'b0;
            busy              <= 1'b0;
        end else if (!hold_level) begin
            // a tied pin stays put, a floating source is no help
            clock_mask_serial_in <= ~clock_mask_serial_in;
        end
    end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the secondary clock gating block
// Assumes: board model drives primary reset and the serial mask
// Notes:   SEC_HOLD shortened to 24 so windows stay short
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module testbench;
    import scg_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, secondary_reset_n;
    logic        primary_reset_n, clock_mask_serial_in, clock_mask_strobe;
    logic        bus_power_clock_strap = 1'b0;
    logic        speed_strap = 1'b0;
    logic        test_mode = 1'b0;
    logic        mode_select_a = 1'b1;
    logic        mode_select_b = 1'b0;
    logic        secondary_clock_feedback = 1'b0;
    logic [9:0]  secondary_clock_out, m, sw;
    logic        speed_66mhz, scan_shift_en, mode_compat, mode_reserved;
    logic        go = 1'b0;
    logic        with_reset = 1'b0;
    logic        hold_level = 1'b0;
    logic        slow = 1'b0;
    logic [9:0]  mask_value = 10'h000;
    logic        busy;
    int          bad_count = 0;
    int          n_tests = 0;

    always #10 mclk = ~mclk;

    scg_clock_ctrl #(.NUM_CLK(10), .CLK_HALF(1), .SEC_HOLD(24)) DUT (
        .mclk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .primary_reset_n, .clock_mask_serial_in, .clock_mask_strobe,
        .bus_power_clock_strap, .speed_strap, .test_mode, .mode_select_a,
        .mode_select_b, .secondary_clock_feedback, .secondary_clock_out,
        .secondary_reset_n, .speed_66mhz, .scan_shift_en, .mode_compat,
        .mode_reserved);

    scg_board_model board (
        .mclk, .go, .with_reset, .hold_level, .slow, .mask_value,
        .primary_reset_n, .clock_mask_serial_in, .clock_mask_strobe, .busy);

    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one Avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
             input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    // board sequence, then wait out the secondary reset hold
    task load(input logic wr_rst, input logic hold, input logic sl,
              input logic [9:0] v);
        @(posedge mclk);
        with_reset <= wr_rst;
        hold_level <= hold;
        slow       <= sl;
        mask_value <= v;
        go         <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy !== 1'b0) @(posedge mclk);
        if (wr_rst) check("sec_reset_in_window", 0, secondary_reset_n);
        if (wr_rst && !sl) begin
            bus(0, `SCG_STATUS_OFS, 32'h0, 4'hF);
            check("status_loaded", 2'b11, {rd[8], rd[4]});
        end
        while (secondary_reset_n !== 1'b1) @(posedge mclk);
    endtask

    // enabled outputs toggle every mclk cycle, disabled park high, B2 parks low
    task clocks(input logic [9:0] dis, input logic b2);
        logic [9:0] c0, c1, et, ep, gp;
        repeat (3) @(posedge mclk);
        @(negedge mclk) c0 = secondary_clock_out;
        @(negedge mclk) c1 = secondary_clock_out;
        et = b2 ? 10'h000 : ~dis;
        ep = b2 ? 10'h000 : dis;
        gp = c0 & ~(c0 ^ c1);
        check("clock_toggle", et, c0 ^ c1);
        check("clock_park", ep, gp);
    endtask

    // strap decode: {speed66, scan shift, compat, reserved}
    function automatic logic [3:0] straps(input logic [3:0] s);
        return {s[2] & ~s[3], s[3] & ~s[2], s[1], ~s[1] & ~s[0]};
    endfunction

    initial begin
        logic [3:0] e;
        void'($urandom(35));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(0, 5'(i * 4), 32'h0, 4'hF);
            check("reg_reset", 0, i == 4 ? rd & 32'h0C0 : rd);
        end
        bus(1, `SCG_MASK_OFS, 32'hFFFFFFFF, 4'hF);
        bus(1, 5'h14, 32'hFFFFFFFF, 4'hF);
        bus(0, 5'h14, 32'h0, 4'hF);
        check("unmapped_read", 0, rd);
        bus(0, `SCG_MASK_OFS, 32'h0, 4'hF);
        check("mask_read_only", 0, rd);
        load(1, 1, 0, 10'h000);
        clocks(10'h000, 0);
        load(1, 1, 0, 10'h3FF);
        clocks(10'h3FF, 0);
        for (int k = 0; k < 4; k++) begin
            m = 10'($urandom);
            load(1, 0, k[0], m);
            bus(0, `SCG_MASK_OFS, 32'h0, 4'hF);
            check("mask_loaded", {22'h0, m}, rd);
            clocks(m, 0);
        end
        load(0, 0, 0, ~m);
        bus(0, `SCG_MASK_OFS, 32'h0, 4'hF);
        check("mask_outside_window", {22'h0, m}, rd);
        sw = 10'($urandom);
        bus(1, `SCG_CLK_CTRL_OFS, {22'h0, sw}, 4'hF);
        clocks(m | sw, 0);
        bus(1, `SCG_CLK_CTRL_OFS, 32'h0, 4'h2);
        bus(0, `SCG_CLK_CTRL_OFS, 32'h0, 4'hF);
        check("ctrl_lane", {22'h0, sw & 10'h0FF}, rd);
        sw = sw & 10'h0FF;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) bus_power_clock_strap <= i[2];
            bus(1, `SCG_PM_CTRL_OFS, 32'(i[1:0]), 4'h1);
            clocks(m | sw, i[2] && i[1:0] == SCG_PM_D3HOT);
            bus(0, `SCG_STATUS_OFS, 32'h0, 4'hF);
            check("status_b2", {i == 7, i[2]}, rd[7:6]);
        end
        bus(1, `SCG_PM_CTRL_OFS, 32'h0, 4'h1);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            {test_mode, speed_strap, mode_select_a, mode_select_b} <= 4'(i);
            secondary_clock_feedback <= 1'($urandom);
            repeat (3) @(posedge mclk);
            e = straps(4'(i));
            check("strap_out", e, {speed_66mhz, scan_shift_en, mode_compat,
                  mode_reserved});
            bus(0, `SCG_STATUS_OFS, 32'h0, 4'hF);
            check("status_strap", {secondary_clock_feedback, 1'b0, e[1:0],
                  e[2], e[3]}, rd[5:0]);
        end
        bus(1, `SCG_BRIDGE_CTRL_OFS, 32'h1, 4'h1);
        repeat (2) @(posedge mclk);
        check("bridge_reset", 0, secondary_reset_n);
        bus(1, `SCG_BRIDGE_CTRL_OFS, 32'h0, 4'h1);
        while (secondary_reset_n !== 1'b1) @(posedge mclk);
        check("bridge_release", 1, secondary_reset_n);
        end_of_test;
    end

    // hang guard, well beyond the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
